// file: cmp_timer_pkg.sv
/*
 * Package for the dual-mode compare timer: register offsets, field
 * positions, reset values and the power-state enumeration.
 * Assumes a 32-bit APB slave with byte-wide registers in the low bits.
 */
package cmp_timer_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h04;
	localparam logic [7:0] OFS_COUNTER_HIGH = 8'h08;
	localparam logic [7:0] OFS_COUNTER_LOW = 8'h0C;
	localparam logic [7:0] OFS_COMPARE_HIGH = 8'h10;
	localparam logic [7:0] OFS_COMPARE_LOW = 8'h14;
	localparam logic [7:0] OFS_CONFIG = 8'h18;

	// control register fields
	localparam int CTL_HIGH_LEVEL = 7;
	localparam int CTL_HIGH_SEL_TOP = 6;
	localparam int CTL_HIGH_SEL_LO = 4;
	localparam int CTL_LOW_LEVEL = 3;
	localparam int CTL_LOW_SEL_TOP = 2;
	localparam int CTL_LOW_SEL_LO = 0;

	// control/status register fields
	localparam int ST_HIGH_OVF = 7;
	localparam int ST_HIGH_MATCH = 6;
	localparam int ST_HIGH_OVIE = 5;
	localparam int ST_HIGH_CLR = 4;
	localparam int ST_LOW_OVF = 3;
	localparam int ST_LOW_MATCH = 2;
	localparam int ST_LOW_OVIE = 1;
	localparam int ST_LOW_CLR = 0;

	// config register fields
	localparam int CFG_EDGE_SEL = 0;
	localparam int CFG_LOW_IRQ_EN = 1;
	localparam int CFG_HIGH_IRQ_EN = 2;

	// reset values
	localparam logic [15:0] RST_COUNTER = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'hFFFF;
	localparam logic [7:0] RST_BYTE_REG = 8'h00;
	localparam logic [4:0] RST_DIVIDER = 5'h00;

	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [15:0] WORD_ONES = 16'hFFFF;

	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_SLEEP,
		PM_WATCH,
		PM_SUBACTIVE,
		PM_SUBSLEEP,
		PM_STANDBY
	} power_mode_t;

endpackage

// file: dual_mode_compare_timer.sv
/*
 * Dual-mode compare timer: 16-bit counter with compare register, or two
 * independent 8-bit counters, behind an APB slave with byte registers.
 * Assumes one clock (ref_clk), asynchronous active-high reset, an
 * asynchronous external event pin and a power-state input from the core.
 */
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dual_mode_compare_timer
	import cmp_timer_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and system
	input wire logic external_event_input,
	input wire power_mode_t power_mode,
	output logic high_compare_output,
	output logic low_compare_output,
	output logic high_irq_req,
	output logic low_irq_req
);

	logic [15:0] wide_counter;
	logic [15:0] wide_compare_reg;
	logic [7:0] timer_control_reg;
	logic [7:0] timer_ctrl_status_reg;
	logic [7:0] config_reg;
	logic [7:0] temp_byte;
	logic [4:0] divider;
	logic event_meta;
	logic event_sync;
	logic event_prev;
	logic [3:0] flags;
	logic [3:0] clear_armed;
	logic [3:0] flag_set;
	logic [3:0] flag_wbit;

	logic wr_access;
	logic rd_setup;
	logic addr_hit;
	logic eight_bit_mode;
	logic counter_run;
	logic ext_edge;
	logic low_tick;
	logic high_tick;
	logic low_match;
	logic high_match;
	logic wide_match;
	logic low_ovf;
	logic high_ovf;
	logic [7:0] read_mux;
	logic [7:0] next_status_bits;

	// picks one divider tap; shared by both halves
	function automatic logic prescale_tick(input logic [1:0] sel, input logic [4:0] div);
		case (sel)
			2'h0: prescale_tick = &div[4:0];
			2'h1: prescale_tick = &div[3:0];
			2'h2: prescale_tick = &div[1:0];
			default: prescale_tick = div[0];
		endcase
	endfunction

	function automatic logic is_wr(input logic [7:0] addr, input logic [7:0] ofs, input logic acc);
		is_wr = acc && (addr == ofs);
	endfunction

	assign wr_access = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign eight_bit_mode = timer_control_reg[CTL_HIGH_SEL_TOP];
	assign counter_run = (power_mode == PM_ACTIVE) || (power_mode == PM_SLEEP);

	// free-running prescaler
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			divider <= RST_DIVIDER;
		end else begin
			divider <= divider + 5'h01;
		end
	end

	// event pin synchroniser and edge detector
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			event_meta <= 1'b0;
			event_sync <= 1'b0;
			event_prev <= 1'b0;
		end else begin
			event_meta <= external_event_input;
			event_sync <= event_meta;
			event_prev <= event_sync;
		end
	end

	// edge select 1 counts rising, 0 falling
	assign ext_edge = config_reg[CFG_EDGE_SEL] ? (event_sync && !event_prev)
		: (!event_sync && event_prev);

	always_comb begin
		if (!timer_control_reg[CTL_LOW_SEL_TOP]) begin
			low_tick = counter_run && ext_edge;
		end else begin
			low_tick = counter_run
				&& prescale_tick(timer_control_reg[CTL_LOW_SEL_LO +: 2], divider);
		end
		high_tick = counter_run && eight_bit_mode
			&& prescale_tick(timer_control_reg[CTL_HIGH_SEL_LO +: 2], divider);
	end

	// match events fire on the count that leaves the matching value
	always_comb begin
		low_match = low_tick && (wide_counter[7:0] == wide_compare_reg[7:0])
			&& !is_wr(paddr, OFS_COMPARE_LOW, wr_access);
		wide_match = low_tick && (wide_counter == wide_compare_reg)
			&& !is_wr(paddr, OFS_COMPARE_LOW, wr_access);
		high_match = eight_bit_mode ? (high_tick && (wide_counter[15:8] == wide_compare_reg[15:8])
			&& !is_wr(paddr, OFS_COMPARE_HIGH, wr_access)) : wide_match;
		low_ovf = low_tick && (wide_counter[7:0] == BYTE_ONES)
			&& !is_wr(paddr, OFS_COUNTER_LOW, wr_access);
		if (eight_bit_mode) begin
			high_ovf = high_tick && (wide_counter[15:8] == BYTE_ONES)
				&& !is_wr(paddr, OFS_COUNTER_HIGH, wr_access);
		end else begin
			high_ovf = low_tick && (wide_counter == WORD_ONES)
				&& !is_wr(paddr, OFS_COUNTER_LOW, wr_access);
		end
	end

	// counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wide_counter <= RST_COUNTER;
		end else if (eight_bit_mode) begin
			if (is_wr(paddr, OFS_COUNTER_LOW, wr_access)) begin
				wide_counter[7:0] <= pwdata[7:0];
			end else if (low_tick) begin
				if (low_match && timer_ctrl_status_reg[ST_LOW_CLR]) begin
					wide_counter[7:0] <= 8'h00;
				end else begin
					wide_counter[7:0] <= wide_counter[7:0] + 8'h01;
				end
			end
			if (is_wr(paddr, OFS_COUNTER_HIGH, wr_access)) begin
				wide_counter[15:8] <= pwdata[7:0];
			end else if (high_tick) begin
				if (high_match && timer_ctrl_status_reg[ST_HIGH_CLR]) begin
					wide_counter[15:8] <= 8'h00;
				end else begin
					wide_counter[15:8] <= wide_counter[15:8] + 8'h01;
				end
			end
		end else begin
			if (is_wr(paddr, OFS_COUNTER_LOW, wr_access)) begin
				wide_counter <= {temp_byte, pwdata[7:0]};
			end else if (low_tick) begin
				if (wide_match && timer_ctrl_status_reg[ST_HIGH_CLR]) begin
					wide_counter <= 16'h0000;
				end else begin
					// carry into upper byte only on lower byte rollover
					wide_counter <= wide_counter + 16'h0001;
				end
			end
		end
	end

	// compare register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wide_compare_reg <= RST_COMPARE;
		end else if (eight_bit_mode) begin
			if (is_wr(paddr, OFS_COMPARE_LOW, wr_access)) begin
				wide_compare_reg[7:0] <= pwdata[7:0];
			end
			if (is_wr(paddr, OFS_COMPARE_HIGH, wr_access)) begin
				wide_compare_reg[15:8] <= pwdata[7:0];
			end
		end else if (is_wr(paddr, OFS_COMPARE_LOW, wr_access)) begin
			wide_compare_reg <= {temp_byte, pwdata[7:0]};
		end
	end

	// temporary byte for paired accesses
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			temp_byte <= 8'h00;
		end else if (!eight_bit_mode) begin
			if (is_wr(paddr, OFS_COUNTER_HIGH, wr_access) || is_wr(paddr, OFS_COMPARE_HIGH, wr_access)) begin
				temp_byte <= pwdata[7:0];
			end else if (is_wr(paddr, OFS_COUNTER_HIGH, rd_setup)) begin
				temp_byte <= wide_counter[7:0];
			end
		end
	end

	// control and config registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_control_reg <= RST_BYTE_REG;
			config_reg <= RST_BYTE_REG;
		end else begin
			if (is_wr(paddr, OFS_CONTROL, wr_access)) begin
				timer_control_reg <= pwdata[7:0];
			end
			if (is_wr(paddr, OFS_CONFIG, wr_access)) begin
				config_reg <= {5'h00, pwdata[2:0]};
			end
		end
	end

	// flag order: high ovf, high match, low ovf, low match
	assign flag_set = {high_ovf, high_match, low_ovf, low_match};
	assign flag_wbit = {pwdata[ST_HIGH_OVF], pwdata[ST_HIGH_MATCH], pwdata[ST_LOW_OVF], pwdata[ST_LOW_MATCH]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					flags[gi] <= 1'b0;
					clear_armed[gi] <= 1'b0;
				end else begin
					if (flag_set[gi]) begin
						flags[gi] <= 1'b1;
					end else if (is_wr(paddr, OFS_CTRL_STATUS, wr_access) && clear_armed[gi]
						&& !flag_wbit[gi]) begin
						flags[gi] <= 1'b0;
					end
					if (is_wr(paddr, OFS_CTRL_STATUS, rd_setup) && flags[gi]) begin
						clear_armed[gi] <= 1'b1;
					end else if (is_wr(paddr, OFS_CTRL_STATUS, wr_access)) begin
						clear_armed[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// enable and clear bits of the status register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			next_status_bits <= RST_BYTE_REG;
		end else if (is_wr(paddr, OFS_CTRL_STATUS, wr_access)) begin
			next_status_bits <= {2'h0, pwdata[5:4], 2'h0, pwdata[1:0]};
		end
	end

	assign timer_ctrl_status_reg = {flags[3], flags[2], next_status_bits[5:4],
		flags[1], flags[0], next_status_bits[1:0]};

	// compare output pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			high_compare_output <= 1'b0;
			low_compare_output <= 1'b0;
		end else if (is_wr(paddr, OFS_CONTROL, wr_access)) begin
			high_compare_output <= pwdata[CTL_HIGH_LEVEL];
			low_compare_output <= pwdata[CTL_LOW_LEVEL];
		end else begin
			if (high_match) begin
				high_compare_output <= !high_compare_output;
			end
			if (low_match) begin
				low_compare_output <= !low_compare_output;
			end
		end
	end

	// interrupt requests
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			high_irq_req <= 1'b0;
			low_irq_req <= 1'b0;
		end else begin
			high_irq_req <= config_reg[CFG_HIGH_IRQ_EN] && (timer_ctrl_status_reg[ST_HIGH_MATCH]
				|| (timer_ctrl_status_reg[ST_HIGH_OVF] && timer_ctrl_status_reg[ST_HIGH_OVIE]));
			low_irq_req <= config_reg[CFG_LOW_IRQ_EN] && (timer_ctrl_status_reg[ST_LOW_MATCH]
				|| (timer_ctrl_status_reg[ST_LOW_OVF] && timer_ctrl_status_reg[ST_LOW_OVIE]));
		end
	end

	// read mux and bus answer
	always_comb begin
		addr_hit = 1'b1;
		case (paddr)
			OFS_CONTROL: read_mux = timer_control_reg;
			OFS_CTRL_STATUS: read_mux = timer_ctrl_status_reg;
			OFS_COUNTER_HIGH: read_mux = wide_counter[15:8];
			OFS_COUNTER_LOW: read_mux = eight_bit_mode ? wide_counter[7:0] : temp_byte;
			OFS_COMPARE_HIGH: read_mux = wide_compare_reg[15:8];
			OFS_COMPARE_LOW: read_mux = wide_compare_reg[7:0];
			OFS_CONFIG: read_mux = config_reg;
			default: begin
				read_mux = 8'h00;
				addr_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= {24'h000000, read_mux};
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence cnt_high_read_s;
		rd_setup && (paddr == OFS_COUNTER_HIGH) && !eight_bit_mode;
	endsequence

	sequence level_write_s;
		wr_access && (paddr == OFS_CONTROL);
	endsequence

	low_ovf_gate_a: assert property (!config_reg[CFG_LOW_IRQ_EN]
		|| (!timer_ctrl_status_reg[ST_LOW_OVIE] && !timer_ctrl_status_reg[ST_LOW_MATCH]) |=> !low_irq_req)
		else $error("low irq without enable");
	low_clear_a: assert property (eight_bit_mode && low_match && timer_ctrl_status_reg[ST_LOW_CLR]
		&& !wr_access |=> wide_counter[7:0] == 8'h00)
		else $error("low half not cleared on match");
	pair_write_a: assert property (!eight_bit_mode && wr_access && paddr == OFS_COUNTER_LOW
		|=> wide_counter == {$past(temp_byte), $past(pwdata[7:0])})
		else $error("paired counter write wrong");
	pair_read_a: assert property (cnt_high_read_s |=> temp_byte == $past(wide_counter[7:0])
		&& prdata[7:0] == $past(wide_counter[15:8]))
		else $error("counter upper read did not latch lower byte");
	compare_read_a: assert property (rd_setup && paddr == OFS_COMPARE_LOW
		|=> prdata[7:0] == $past(wide_compare_reg[7:0]) && $stable(temp_byte))
		else $error("compare read not direct");
	reset_value_a: assert property ($fell(rst) |-> wide_counter == RST_COUNTER
		&& wide_compare_reg == RST_COMPARE && timer_control_reg == 8'h00)
		else $error("reset values wrong");
	wide_match_a: assert property (!eight_bit_mode && wide_match && !wr_access
		|=> timer_ctrl_status_reg[ST_HIGH_MATCH] && high_compare_output != $past(high_compare_output))
		else $error("sixteen-bit match effects missing");
	wide_ovf_a: assert property (!eight_bit_mode && low_tick && wide_counter == WORD_ONES && !wr_access
		|=> timer_ctrl_status_reg[ST_HIGH_OVF])
		else $error("sixteen-bit overflow flag not set");
	flag_no_set_a: assert property (!flags[3] && !flag_set[3] |=> !flags[3])
		else $error("overflow flag set without event");
	// equal bytes alone must not raise the flag until a tick
	no_early_match_a: assert property ((wide_counter[7:0] == wide_compare_reg[7:0]) && !low_tick
		&& !timer_ctrl_status_reg[ST_LOW_MATCH] |=> !timer_ctrl_status_reg[ST_LOW_MATCH])
		else $error("match before counter clock");
	level_write_a: assert property (level_write_s
		|=> high_compare_output == $past(pwdata[CTL_HIGH_LEVEL])
		&& low_compare_output == $past(pwdata[CTL_LOW_LEVEL]))
		else $error("level write not immediate");
	halt_a: assert property (!counter_run && !wr_access |=> $stable(wide_counter))
		else $error("counter ran while halted");

endmodule

// file: host_model.sv
/*
 * Host-side model: APB master for the timer registers, source of the
 * external event pin and of the power state.
 * Assumes the timer samples everything on the rising edge of ref_clk.
 */
`timescale 1ns/1ps
module host_model
	import cmp_timer_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and system
	output logic ev_pin,
	output power_mode_t pm
);
	int n_to = 0;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		ev_pin = 1'b0;
		pm = PM_ACTIVE;
	end

	// request held until pready is seen high at a rising edge, or for at most 32 cycles
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic err);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 32);
		if (pready !== 1'b1)
			n_to++;
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic e);
		xfer(1'b0, a, 8'h00, q, e);
	endtask

	// wide access: upper byte first, low byte four above it
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[15:8]);
		wr(a + 8'h04, d[7:0]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		logic e;
		rd(a, d[15:8], e);
		rd(a + 8'h04, d[7:0], e);
	endtask

	// each level held three cycles
	task automatic pulse(input int n);
		repeat (n) begin
			ev_pin <= 1'b1;
			repeat (3) @(posedge ref_clk);
			ev_pin <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	task automatic set_pm(input power_mode_t m);
		@(posedge ref_clk);
		pm <= m;
	endtask
endmodule

// file: tb_top.sv
/*
 * Self-checking bench for the dual-mode compare timer: register traffic,
 * event pulses and power states driven through the host model.
 * Assumes the timer package and the host model are compiled first.
 */
`timescale 1ns/1ps
module tb_top
	import cmp_timer_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, ev_pin;
	logic hi_pin, lo_pin, hi_irq, lo_irq, e;
	logic [7:0] paddr, q, a, b;
	logic [31:0] pwdata, prdata;
	logic [15:0] w, w2, w3;
	power_mode_t pm;
	power_mode_t halts[4] = '{PM_WATCH, PM_SUBACTIVE, PM_SUBSLEEP, PM_STANDBY};
	int n_mismatch = 0;
	int cmp_count = 0;
	int n, t;

	always #4 ref_clk = ~ref_clk;

	dual_mode_compare_timer dut_u (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_event_input(ev_pin), .power_mode(pm), .high_compare_output(hi_pin),
		.low_compare_output(lo_pin), .high_irq_req(hi_irq), .low_irq_req(lo_irq)
	);

	host_model host_u (
		.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ev_pin(ev_pin), .pm(pm)
	);

	// counter ticks over the 259-cycle run window
	function automatic int ticks(input int s);
		int d;
		case (s)
			0: d = 32;
			1: d = 16;
			2: d = 4;
			default: d = 2;
		endcase
		return 259 / d;
	endfunction

	task automatic finish_test;
		n_mismatch += host_u.n_to;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] x, input logic [7:0] g);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic chk1(input string nm, input logic x, input logic g);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", nm, x, g);
		end
	endtask

	task automatic chkr(input string nm, input int lo, input int hi, input logic [15:0] g);
		cmp_count++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("Error %s expected %0d..%0d seen %h", nm, lo, hi, g);
		end
	endtask

	task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] x);
		host_u.rd(ad, q, e);
		chk8(nm, x, q);
	endtask

	task automatic wait_st(input logic [7:0] m);
		q = 8'h00;
		for (int i = 0; i < 200 && (q & m) !== m; i++)
			host_u.rd(OFS_CTRL_STATUS, q, e);
		if ((q & m) !== m) begin
			n_mismatch++;
			$display("Error wait_status expected %h seen %h", m, q);
			finish_test();
		end
	endtask

	initial begin
		t = $urandom(32'hEE8F5F89);
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rdc("control", OFS_CONTROL, 8'h00);
		rdc("status", OFS_CTRL_STATUS, 8'h00);
		rdc("config", OFS_CONFIG, 8'h00);
		rdc("cnt_hi", OFS_COUNTER_HIGH, 8'h00);
		rdc("cnt_lo", OFS_COUNTER_LOW, 8'h00);
		rdc("cmp_hi", OFS_COMPARE_HIGH, 8'hFF);
		rdc("cmp_lo", OFS_COMPARE_LOW, 8'hFF);
		host_u.rd(8'h1C, q, e);
		chk1("unmapped_err", 1'b1, e);
		chk8("unmapped_data", 8'h00, q);
		// wide writes through the holding register
		a = 8'($urandom_range(64, 8));
		b = 8'($urandom_range(64, 8));
		host_u.wr(OFS_COMPARE_HIGH, a);
		rdc("cmp_hi_held", OFS_COMPARE_HIGH, 8'hFF);
		host_u.wr(OFS_COMPARE_LOW, b);
		rdc("cmp_hi_new", OFS_COMPARE_HIGH, a);
		w = 16'($urandom);
		host_u.wr16(OFS_COUNTER_HIGH, w);
		rdc("cnt_hi_rd", OFS_COUNTER_HIGH, w[15:8]);
		rdc("cmp_lo_mid", OFS_COMPARE_LOW, b);
		rdc("cnt_lo_rd", OFS_COUNTER_LOW, w[7:0]);
		// rollover, flags and overflow request
		host_u.wr16(OFS_COMPARE_HIGH, WORD_ONES);
		host_u.wr16(OFS_COUNTER_HIGH, 16'hFFF0);
		host_u.wr(OFS_CTRL_STATUS, 8'h20);
		host_u.wr(OFS_CONTROL, 8'h07);
		wait_st(8'hC0);
		chk1("hi_pin_toggle", 1'b1, hi_pin);
		chk1("lo_pin_toggle", 1'b1, lo_pin);
		chk1("hi_irq_off", 1'b0, hi_irq);
		host_u.wr(OFS_CONTROL, 8'h00);
		rdc("st_flags", OFS_CTRL_STATUS, 8'hEC);
		host_u.wr(OFS_CTRL_STATUS, 8'hA8);
		rdc("st_keep", OFS_CTRL_STATUS, 8'hA8);
		host_u.wr(OFS_CONFIG, 8'h04);
		repeat (2) @(posedge ref_clk);
		chk1("hi_irq_on", 1'b1, hi_irq);
		host_u.wr(OFS_CTRL_STATUS, 8'h88);
		repeat (2) @(posedge ref_clk);
		chk1("hi_irq_gated", 1'b0, hi_irq);
		host_u.rd(OFS_CTRL_STATUS, q, e);
		host_u.wr(OFS_CTRL_STATUS, 8'h00);
		rdc("st_clear", OFS_CTRL_STATUS, 8'h00);
		host_u.wr(OFS_CTRL_STATUS, 8'hCC);
		rdc("st_noset", OFS_CTRL_STATUS, 8'h00);
		host_u.wr(OFS_CONFIG, 8'h00);
		for (n = 1; n >= 0; n--) begin
			host_u.wr(OFS_CONTROL, n[0] ? 8'h88 : 8'h00);
			@(posedge ref_clk);
			chk1("hi_level", n[0], hi_pin);
			chk1("lo_level", n[0], lo_pin);
		end
		// every internal divider, the two fastest carrying into the upper byte
		for (n = 0; n < 4; n++) begin
			host_u.wr16(OFS_COUNTER_HIGH, 16'h00C0);
			host_u.wr(OFS_CONTROL, {5'b00000, 1'b1, n[1:0]});
			repeat (256) @(posedge ref_clk);
			host_u.wr(OFS_CONTROL, 8'h00);
			host_u.rd16(OFS_COUNTER_HIGH, w);
			chkr("prescale", 192 + ticks(n) - 2, 192 + ticks(n) + 2, w);
		end
		// external events, rising then falling edges
		host_u.wr16(OFS_COUNTER_HIGH, 16'h0000);
		t = 0;
		for (n = 1; n >= 0; n--) begin
			host_u.wr(OFS_CONFIG, {7'h00, n[0]});
			a = 8'($urandom_range(12, 3));
			host_u.pulse(a);
			t += a;
			repeat (4) @(posedge ref_clk);
			host_u.rd16(OFS_COUNTER_HIGH, w);
			chkr("events", t, t, w);
		end
		// match with clear; halted power states
		w = 16'($urandom_range(48, 16));
		host_u.wr16(OFS_COMPARE_HIGH, w);
		host_u.wr16(OFS_COUNTER_HIGH, w);
		host_u.rd(OFS_CTRL_STATUS, q, e);
		host_u.wr(OFS_CTRL_STATUS, 8'h10);
		repeat (20) @(posedge ref_clk);
		rdc("no_early_match", OFS_CTRL_STATUS, 8'h10);
		host_u.wr(OFS_CONTROL, 8'h07);
		wait_st(8'h40);
		foreach (halts[i]) begin
			host_u.set_pm(halts[i]);
			host_u.rd16(OFS_COUNTER_HIGH, w2);
			chkr("cnt_cleared", 0, w, w2);
			repeat (40) @(posedge ref_clk);
			host_u.rd16(OFS_COUNTER_HIGH, w3);
			chkr("cnt_halted", w2, w2, w3);
		end
		rdc("cmp_kept", OFS_COMPARE_LOW, w[7:0]);
		host_u.rd(OFS_CTRL_STATUS, q, e);
		host_u.wr(OFS_CTRL_STATUS, 8'h10);
		host_u.set_pm(PM_SLEEP);
		wait_st(8'h40);
		// two independent byte counters
		host_u.set_pm(PM_WATCH);
		host_u.wr(OFS_CONTROL, 8'h77);
		host_u.wr(OFS_COMPARE_LOW, b);
		host_u.wr(OFS_COMPARE_HIGH, 8'h00);
		rdc("cmp_lo8", OFS_COMPARE_LOW, b);
		host_u.wr(OFS_COUNTER_LOW, 8'h00);
		host_u.wr(OFS_COUNTER_HIGH, 8'hF0);
		rdc("cnt_lo8", OFS_COUNTER_LOW, 8'h00);
		host_u.rd(OFS_CTRL_STATUS, q, e);
		host_u.wr(OFS_CTRL_STATUS, 8'h01);
		rdc("st_8bit", OFS_CTRL_STATUS, 8'h01);
		host_u.set_pm(PM_ACTIVE);
		wait_st(8'h84);
		host_u.set_pm(PM_WATCH);
		host_u.rd(OFS_COUNTER_LOW, q, e);
		chkr("lo_cleared", 0, b, {8'h00, q});
		host_u.rd(OFS_COUNTER_HIGH, q, e);
		chkr("hi_wrapped", 0, 64, {8'h00, q});
		// low request from match, then from overflow with its enable
		host_u.wr(OFS_CONFIG, 8'h02);
		repeat (2) @(posedge ref_clk);
		chk1("lo_irq_match", 1'b1, lo_irq);
		host_u.rd(OFS_CTRL_STATUS, q, e);
		host_u.wr(OFS_CTRL_STATUS, 8'h01);
		host_u.wr(OFS_COUNTER_LOW, 8'hFE);
		host_u.set_pm(PM_ACTIVE);
		wait_st(8'h08);
		host_u.set_pm(PM_WATCH);
		chk1("lo_irq_ovf_off", 1'b0, lo_irq);
		host_u.wr(OFS_CTRL_STATUS, 8'h0B);
		repeat (2) @(posedge ref_clk);
		chk1("lo_irq_ovf_on", 1'b1, lo_irq);
		finish_test();
	end
endmodule
